// ==== logic/mcel_defines.svh ====
// offsets, field positions and reset values of the memory error detail log
`ifndef MCEL_DEFINES_SVH
`define MCEL_DEFINES_SVH
`define MCEL_OFF_CTRL 12'h000
`define MCEL_OFF_EVENT 12'h004
`define MCEL_OFF_DATA 12'h008
`define MCEL_OFF_MASKS 12'h00C
`define MCEL_OFF_MISC_LO 12'h010
`define MCEL_OFF_MISC_HI 12'h014
`define MCEL_OFF_ROUTE 12'h018
`define MCEL_CTRL_EXTRA_BIT 1
`define MCEL_CTRL_CTLR_BIT 2
`define MCEL_CTRL_CLEAR_BIT 3
`define MCEL_ID_LSB 9
`define MCEL_ID_MSB 13
`define MCEL_MASK1_LSB 14
`define MCEL_MASK2_LSB 30
`define MCEL_RANK1_LSB 46
`define MCEL_RANK2_LSB 51
`define MCEL_VALID1_BIT 62
`define MCEL_VALID2_BIT 63
`define MCEL_HA_BANK_FIRST 5'h07
`define MCEL_HA_BANK_SECOND 5'h08
`define MCEL_IMC_BANK_FIRST_BASE 5'h09
`define MCEL_IMC_BANK_SECOND_BASE 5'h0D
`define MCEL_MISC_RESET 64'h0000_0000_0000_0000
`endif

// ==== logic/mcel_pkg.sv ====
// types for the memory error detail log
package mcel_pkg;
	typedef enum logic [1:0] {
		MCEL_EV_WR_DATA_PAR,
		MCEL_EV_WR_BE_PAR,
		MCEL_EV_CORR_READ,
		MCEL_EV_OTHER
	} mcel_event_t;
endpackage : mcel_pkg

// ==== logic/mcel_log.sv ====
// memory controller error detail log register with an APB slave
`timescale 1ns/10ps
`default_nettype none
`include "mcel_defines.svh"

// Operation
// - on write data or byte enable parity error, log buffer id in 13:9.
// - second correctable read error logs second failing device id in 13:9.
// - with extra logging, capture device error masks in 29:14 and 45:30.
// - with extra logging, capture failing ranks in 50:46 and 55:51.
// - with extra logging, set bit 62 on first correctable read detail.
// - with extra logging, set bit 63 on second correctable error detail.
// - home agent path routes controller one to bank 7, two to bank 8.
// - per-device capture happens only while control bit 1 is set.
// - controller one logs to banks 9-12, controller two to 13-16.
module mcel_log
	import mcel_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic [4:0] ha_bank_ff,
	output logic [4:0] imc_bank_ff
);
	logic [31:0] ctrl_ff;
	logic [31:0] event_ff;
	logic [31:0] data_ff;
	logic [31:0] masks_ff;
	logic [63:0] misc_ff;
	logic [63:0] nxt_misc;
	logic wr;
	logic rd_ok;
	logic extra_en;
	logic ctlr_sel;
	logic clr;
	logic fire;
	mcel_event_t ev;
	logic [4:0] ev_id;
	logic [4:0] rank;
	logic [1:0] chan;

	assign wr = psel & penable & pwrite;
	assign pready = 1'b1;
	assign extra_en = ctrl_ff[`MCEL_CTRL_EXTRA_BIT];
	assign ctlr_sel = ctrl_ff[`MCEL_CTRL_CTLR_BIT];
	// writing the event register is how the controller side reports a detected error
	assign fire = wr && (paddr == `MCEL_OFF_EVENT);
	assign clr = wr && (paddr == `MCEL_OFF_CTRL) && pwdata[`MCEL_CTRL_CLEAR_BIT];
	assign ev = mcel_event_t'(pwdata[1:0]);
	assign ev_id = pwdata[8:4];
	assign rank = pwdata[16:12];
	assign chan = pwdata[21:20];

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrl_ff <= 32'h0000_0000;
		end else if (wr && paddr == `MCEL_OFF_CTRL) begin
			ctrl_ff <= {28'h000_0000, 1'b0, pwdata[2:0]};
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			event_ff <= 32'h0000_0000;
		end else if (fire) begin
			event_ff <= pwdata;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			data_ff <= 32'h0000_0000;
			masks_ff <= 32'h0000_0000;
		end else if (wr && paddr == `MCEL_OFF_DATA) begin
			data_ff <= pwdata;
		end else if (wr && paddr == `MCEL_OFF_MASKS) begin
			masks_ff <= pwdata;
		end
	end

	always_comb begin
		nxt_misc = misc_ff;
		if (clr) begin
			nxt_misc = `MCEL_MISC_RESET;
		end
		if (fire) begin
			case (ev)
				MCEL_EV_WR_DATA_PAR, MCEL_EV_WR_BE_PAR: begin
					nxt_misc[`MCEL_ID_MSB:`MCEL_ID_LSB] = ev_id;
				end
				MCEL_EV_CORR_READ: begin
					// detail capture gated by the extra-logging enable
					if (extra_en && !misc_ff[`MCEL_VALID1_BIT]) begin
						nxt_misc[`MCEL_MASK1_LSB +: 16] = masks_ff[15:0];
						nxt_misc[`MCEL_RANK1_LSB +: 5] = rank;
						nxt_misc[`MCEL_VALID1_BIT] = 1'b1;
					end else if (extra_en && !misc_ff[`MCEL_VALID2_BIT]) begin
						nxt_misc[`MCEL_ID_MSB:`MCEL_ID_LSB] = ev_id;
						nxt_misc[`MCEL_MASK2_LSB +: 16] = masks_ff[31:16];
						nxt_misc[`MCEL_RANK2_LSB +: 5] = rank;
						nxt_misc[`MCEL_VALID2_BIT] = 1'b1;
					end
				end
				default: begin
					nxt_misc = nxt_misc;
				end
			endcase
		end
		nxt_misc[61:56] = 6'h00;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			misc_ff <= `MCEL_MISC_RESET;
		end else begin
			misc_ff <= nxt_misc;
		end
	end

	// bank numbers follow the selected controller; the imc bank also adds the channel of the last event
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ha_bank_ff <= 5'h00;
			imc_bank_ff <= 5'h00;
		end else if (fire) begin
			ha_bank_ff <= ctlr_sel ? `MCEL_HA_BANK_SECOND : `MCEL_HA_BANK_FIRST;
			imc_bank_ff <= (ctlr_sel ? `MCEL_IMC_BANK_SECOND_BASE
				: `MCEL_IMC_BANK_FIRST_BASE) + {3'b000, chan};
		end
	end

	always_comb begin
		rd_ok = 1'b1;
		case (paddr)
			`MCEL_OFF_CTRL: prdata = ctrl_ff;
			`MCEL_OFF_EVENT: prdata = event_ff;
			`MCEL_OFF_DATA: prdata = data_ff;
			`MCEL_OFF_MASKS: prdata = masks_ff;
			`MCEL_OFF_MISC_LO: prdata = misc_ff[31:0];
			`MCEL_OFF_MISC_HI: prdata = misc_ff[63:32];
			`MCEL_OFF_ROUTE: prdata = {22'h00_0000, imc_bank_ff, ha_bank_ff};
			default: begin
				prdata = 32'h0000_0000;
				rd_ok = 1'b0;
			end
		endcase
	end

	// unmapped addresses answer with an error in the access phase
	assign pslverr = psel & penable & ~rd_ok;
endmodule : mcel_log
`default_nettype wire

// ==== tb/mcel_props.sv ====
// port checker for the memory error detail log
`timescale 1ns/10ps
`default_nettype none
module mcel_props(
	input wire logic clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [4:0] ha_bank_ff,
	input wire logic [4:0] imc_bank_ff
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	wire acc = psel && penable;
	wire map = paddr <= 12'h018 && paddr[1:0] == 2'h0;
	wire rdhi = acc && !pwrite && paddr == 12'h014;
	property p_rdy; acc |-> pready; endproperty
	a_rdy: assert property (p_rdy) else $error("ready low");
	property p_err; acc && !map |-> pslverr && prdata == 32'h0; endproperty
	a_err: assert property (p_err) else $error("hole open");
	property p_ok; acc && map |-> !pslverr; endproperty
	a_ok: assert property (p_ok) else $error("false error");
	property p_rsv; rdhi |-> prdata[29:24] == 6'h00; endproperty
	a_rsv: assert property (p_rsv) else $error("reserved set");
	property p_v2; rdhi && prdata[31] |-> prdata[30]; endproperty
	a_v2: assert property (p_v2) else $error("valid order");
	property p_ha; ha_bank_ff inside {5'h00, 5'h07, 5'h08}; endproperty
	a_ha: assert property (p_ha) else $error("bad bank");
	property p_b1; ha_bank_ff == 5'h07 |-> imc_bank_ff inside {[5'h09:5'h0C]}; endproperty
	a_b1: assert property (p_b1) else $error("bank one");
	property p_b2; ha_bank_ff == 5'h08 |-> imc_bank_ff inside {[5'h0D:5'h10]}; endproperty
	a_b2: assert property (p_b2) else $error("bank two");
endmodule : mcel_props
bind mcel_log mcel_props u_mcel_props(.*);
`default_nettype wire

// ==== tb/test_mcel_log.sv ====
// bench for the memory error detail log
`timescale 1ns/10ps
`default_nettype none
module test_mcel_log;
	logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [4:0] ha_bank_ff, imc_bank_ff;
	int n_mismatch = 0, n_tests = 0;
	// nibble 1 write, 0 read with expected data
	logic [43:0] rows [23] = '{44'h0_10_00000000, 44'h1_00_00000002, 44'h1_0C_BBBBAAAA,
		44'h1_04_00103052, 44'h0_10_2AAA8000, 44'h0_14_4000C000, 44'h0_18_00000147,
		44'h1_04_0031F1F2, 44'h0_10_EAAABE00, 44'h0_14_C0F8EEEE, 44'h0_18_00000187,
		44'h1_14_FFFFFFFF, 44'h0_14_C0F8EEEE, 44'h1_00_0000000C, 44'h1_04_000000A0,
		44'h0_10_00001400, 44'h0_14_00000000, 44'h0_18_000001A8, 44'h1_04_00000032,
		44'h0_10_00001400, 44'h1_04_00000111, 44'h0_10_00002200, 44'h0_1C_00000000};
	always #2 clk = ~clk;
	mcel_log u_mcel_log(.*);
	task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer
	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e) begin
			n_mismatch++;
			$display("unexpected %s exp %h seen %h", nm, e, s);
		end
	endtask : chk
	task give_verdict;
		$display("mismatches %0d tests %0d", n_mismatch, n_tests);
		if (n_mismatch == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : give_verdict
	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		foreach (rows[i]) begin
			xfer(rows[i][40], {4'h0, rows[i][39:32]}, rows[i][31:0]);
			if (!rows[i][40])
				chk("row", rd, rows[i][31:0]);
			chk("slverr", {31'h0, err}, {31'h0, rows[i][39:32] > 8'h18});
		end
		// reset in mid-run must wipe the low word of the captured log and the bank outputs
		rst <= 1'b1;
		@(posedge clk);
		rst <= 1'b0;
		chk("ha_bank", {27'h0, ha_bank_ff}, 32'h0);
		chk("imc_bank", {27'h0, imc_bank_ff}, 32'h0);
		xfer(1'b0, 12'h010, 32'h0);
		chk("reset", rd, 32'h0);
		xfer(1'b0, 12'h018, 32'h0);
		chk("reset_route", rd, 32'h0);
		give_verdict();
	end
	initial begin
		#4000;
		n_mismatch++;
		give_verdict();
	end
endmodule : test_mcel_log
`default_nettype wire
